//--- hdl/eif_slave.sv
// Operation
// - Write-inhibit high blocks every write to the array.
// - Unconnected write-inhibit reads low, so writes are allowed.
// - Write-inhibit high: ack select and address, never data bytes.
// - After power-on reset release, reset logic and enter standby.
// - Reset asserted again makes the device ignore every instruction.
// - Stop decoded with no write cycle running puts device in standby.
// - Start is SDA falling while SCL high; detected before every transfer.
// - Start is watched at all times except during the write cycle.
// - Stop is SDA rising while SCL high; it ends communication.
// - Read byte answered by no-ack then Stop returns to standby.
// - Stop ending a write instruction starts the internal write cycle.
// - Transmitter releases SDA after eight bits; receiver acks in ninth.
// - SDA sampled on rising SCL while receiving.
// - Select byte: type bits 7..4, chip bits 3..1, direction bit 0.
// - Type 1011b selects the identification page.
// - Respond only when chip field equals the three strap inputs.
// - Direction bit one is read, zero is write.
// - Select match acks in ninth bit; mismatch releases and goes standby.
// - Reads ignore write-inhibit; writes carry one to 128 bytes.
module eif_slave (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Serial link
  input wire logic scl_clk_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Straps and write inhibit
  input wire logic write_inhibit_input_in,
  input wire logic chip_strap_bit0_in,
  input wire logic chip_strap_bit1_in,
  input wire logic chip_strap_bit2_in,
  // Array side
  input wire logic write_busy_in,
  input wire logic [7:0] read_data_in,
  output logic [7:0] rx_byte_out,
  output logic [1:0] rx_index_out,
  output logic rx_valid_out,
  output logic id_page_out,
  output logic read_next_out,
  output logic write_start_out,
  output logic standby_out
);

  function automatic logic sel_match(input logic [7:0] sel, input logic [2:0] ce);
    logic [3:0] kind;
    kind = sel[eif_pkg::SEL_TYPE_HI:eif_pkg::SEL_TYPE_LO];
    sel_match = ((kind == eif_pkg::TYPE_MAIN) || (kind == eif_pkg::TYPE_IDPAGE)) &&
                (sel[eif_pkg::SEL_CE_HI:eif_pkg::SEL_CE_LO] == ce);
  endfunction

  logic [eif_pkg::SYNC_W-1:0] pins_q;
  logic scl_f;
  logic sda_f;
  logic wi_f;
  logic [2:0] ce_f;
  logic scl_d;
  logic sda_d;
  logic start_ev;
  logic stop_ev;
  logic scl_fall;
  logic link_bit;
  logic link_tgl;
  logic t1;
  logic t2;
  logic t3;
  logic bit_ev;
  eif_pkg::eif_state_type state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic rw_bit;
  logic wr_pend;
  logic byte_done;

  // Floating write-inhibit relies on the pad pull-down, so it reads low
  eif_sync #(
    .W(eif_pkg::SYNC_W),
    .RST(eif_pkg::SYNC_RST)
  ) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .raw_in({chip_strap_bit2_in, chip_strap_bit1_in, chip_strap_bit0_in,
             write_inhibit_input_in, sda_in, scl_clk_in}),
    .q_out(pins_q)
  );

  assign scl_f = pins_q[eif_pkg::SYNC_SCL];
  assign sda_f = pins_q[eif_pkg::SYNC_SDA];
  assign wi_f = pins_q[eif_pkg::SYNC_WI];
  assign ce_f = pins_q[eif_pkg::SYNC_CE_HI:eif_pkg::SYNC_CE_LO];

  // Bits are sampled by the master's own clock edge
  eif_link u_link (
    .scl_clk_in(scl_clk_in),
    .rstn_in(rstn_in),
    .sda_in(sda_in),
    .bit_out(link_bit),
    .tgl_out(link_tgl)
  );

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // Toggle crossing; link_bit is held until the next SCL rise, well after bit_ev
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      t1 <= 1'b0;
      t2 <= 1'b0;
      t3 <= 1'b0;
    end else begin
      t1 <= link_tgl;
      t2 <= t1;
      t3 <= t2;
    end
  end

  assign bit_ev = t2 ^ t3;
  assign scl_fall = scl_d & ~scl_f;
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f & ~write_busy_in;
  assign stop_ev = scl_f & scl_d & ~sda_d & sda_f;
  assign byte_done = (state == eif_pkg::ST_RECV) && (bit_cnt == eif_pkg::BIT_FULL) && scl_fall;

  // Protocol state; Stop and Start override every byte phase
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state <= eif_pkg::ST_IDLE;
      bit_cnt <= eif_pkg::BIT_FIRST;
      byte_idx <= eif_pkg::IDX_SEL;
    end else if (stop_ev) begin
      state <= eif_pkg::ST_IDLE;
      bit_cnt <= eif_pkg::BIT_FIRST;
    end else if (start_ev) begin
      state <= eif_pkg::ST_RECV;
      bit_cnt <= eif_pkg::BIT_FIRST;
      byte_idx <= eif_pkg::IDX_SEL;
    end else begin
      case (state)
        eif_pkg::ST_IDLE: begin
          bit_cnt <= eif_pkg::BIT_FIRST;
        end
        eif_pkg::ST_RECV: begin
          if (bit_ev && (bit_cnt != eif_pkg::BIT_FULL)) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (byte_done) begin
            bit_cnt <= eif_pkg::BIT_FIRST;
            if (byte_idx == eif_pkg::IDX_SEL) begin
              state <= sel_match(shreg, ce_f) ? eif_pkg::ST_ACK : eif_pkg::ST_IDLE;
            end else if ((byte_idx == eif_pkg::IDX_DATA) && wi_f) begin
              state <= eif_pkg::ST_WAIT;
            end else begin
              state <= eif_pkg::ST_ACK;
            end
          end
        end
        eif_pkg::ST_ACK: begin
          // The ninth rise also toggles the link and is not a data bit
          if (scl_fall) begin
            bit_cnt <= eif_pkg::BIT_FIRST;
            state <= (rw_bit == eif_pkg::RW_READ) ? eif_pkg::ST_SEND : eif_pkg::ST_RECV;
            if (byte_idx != eif_pkg::IDX_DATA) begin
              byte_idx <= byte_idx + 2'h1;
            end
          end
        end
        eif_pkg::ST_SEND: begin
          if (bit_ev && (bit_cnt != eif_pkg::BIT_FULL)) begin
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (scl_fall && (bit_cnt == eif_pkg::BIT_FULL)) begin
            state <= eif_pkg::ST_MACK;
            bit_cnt <= eif_pkg::BIT_FIRST;
          end
        end
        eif_pkg::ST_MACK: begin
          if (bit_ev) begin
            if (link_bit) begin
              state <= eif_pkg::ST_WAIT;
            end else begin
              bit_cnt <= eif_pkg::BIT_MACK_SEEN;
            end
          end else if (scl_fall && (bit_cnt == eif_pkg::BIT_MACK_SEEN)) begin
            state <= eif_pkg::ST_SEND;
            bit_cnt <= eif_pkg::BIT_FIRST;
          end
        end
        eif_pkg::ST_WAIT: begin
          bit_cnt <= eif_pkg::BIT_FIRST;
        end
        default: begin
          state <= eif_pkg::ST_IDLE;
          bit_cnt <= eif_pkg::BIT_FIRST;
        end
      endcase
    end
  end

  // Receive shifter, first bit ends up in bit 7
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      shreg <= eif_pkg::RST_BYTE;
    end else if ((state == eif_pkg::ST_RECV) && bit_ev && (bit_cnt != eif_pkg::BIT_FULL)) begin
      shreg <= {shreg[6:0], link_bit};
    end
  end

  // Direction and page are latched only from a matching select byte
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rw_bit <= 1'b0;
      id_page_out <= 1'b0;
    end else if (byte_done && (byte_idx == eif_pkg::IDX_SEL) && sel_match(shreg, ce_f)) begin
      rw_bit <= shreg[eif_pkg::SEL_RW];
      id_page_out <= (shreg[eif_pkg::SEL_TYPE_HI:eif_pkg::SEL_TYPE_LO] == eif_pkg::TYPE_IDPAGE);
    end
  end

  // A write is armed only by an acknowledged data byte
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wr_pend <= 1'b0;
    end else if (stop_ev || start_ev) begin
      wr_pend <= 1'b0;
    end else if (byte_done && (byte_idx == eif_pkg::IDX_DATA)) begin
      // A refused byte disarms earlier ones too, so a late inhibit still blocks the write
      wr_pend <= !wi_f;
    end
  end

  // Only a Stop in the slot right after a data ack starts the write cycle;
  // the slot's own SCL rise is already counted by the time the Stop is seen
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      write_start_out <= 1'b0;
    end else begin
      write_start_out <= stop_ev && wr_pend && (state == eif_pkg::ST_RECV) &&
                         (bit_cnt <= eif_pkg::BIT_STOP_SLOT);
    end
  end

  // Accepted bytes go to the array; blocked data bytes still load rx_byte_out but never raise rx_valid_out
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rx_valid_out <= 1'b0;
      rx_byte_out <= eif_pkg::RST_BYTE;
      rx_index_out <= eif_pkg::IDX_SEL;
    end else begin
      rx_valid_out <= byte_done && !((byte_idx == eif_pkg::IDX_DATA) && wi_f) &&
                      !((byte_idx == eif_pkg::IDX_SEL) && !sel_match(shreg, ce_f));
      if (byte_done) begin
        rx_byte_out <= shreg;
        rx_index_out <= byte_idx;
      end
    end
  end

  // Transmit shifter; a new byte is requested as each one is loaded
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tx <= eif_pkg::RST_BYTE;
      read_next_out <= 1'b0;
    end else begin
      read_next_out <= 1'b0;
      if (scl_fall && (((state == eif_pkg::ST_ACK) && (rw_bit == eif_pkg::RW_READ)) ||
          ((state == eif_pkg::ST_MACK) && (bit_cnt == eif_pkg::BIT_MACK_SEEN) && !bit_ev))) begin
        tx <= read_data_in;
        read_next_out <= 1'b1;
      end else if (scl_fall && (state == eif_pkg::ST_SEND)) begin
        tx <= {tx[6:0], 1'b1};
      end
    end
  end

  // Open-drain SDA: enable low pulls the line, changes on SCL falls and is released on Start or Stop
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      sda_oe_n_out <= eif_pkg::RST_OE_N;
      sda_out <= eif_pkg::RST_SDA_OUT;
    end else begin
      sda_out <= eif_pkg::RST_SDA_OUT;
      if (stop_ev || start_ev) begin
        sda_oe_n_out <= 1'b1;
      end else if (byte_done) begin
        sda_oe_n_out <= !(((byte_idx == eif_pkg::IDX_SEL) && sel_match(shreg, ce_f)) ||
                          (byte_idx == eif_pkg::IDX_ADDR_HI) || (byte_idx == eif_pkg::IDX_ADDR_LO) ||
                          ((byte_idx == eif_pkg::IDX_DATA) && !wi_f));
      end else if (scl_fall && (state == eif_pkg::ST_ACK)) begin
        sda_oe_n_out <= (rw_bit == eif_pkg::RW_READ) ? read_data_in[7] : 1'b1;
      end else if (scl_fall && (state == eif_pkg::ST_MACK) && (bit_cnt == eif_pkg::BIT_MACK_SEEN)) begin
        sda_oe_n_out <= read_data_in[7];
      end else if (scl_fall && (state == eif_pkg::ST_SEND)) begin
        sda_oe_n_out <= (bit_cnt == eif_pkg::BIT_FULL) ? 1'b1 : tx[6];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      standby_out <= 1'b1;
    end else begin
      standby_out <= (state == eif_pkg::ST_IDLE) && !write_busy_in;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  property p_data_nack_wi;
    byte_done && (byte_idx == eif_pkg::IDX_DATA) && wi_f |=> sda_oe_n_out && (state == eif_pkg::ST_WAIT)
      && !rx_valid_out && !wr_pend;
  endproperty
  a_data_nack_wi: assert property (p_data_nack_wi) else $error("data byte acked under write inhibit");

  property p_addr_ack_wi;
    byte_done && ((byte_idx == eif_pkg::IDX_ADDR_HI) || (byte_idx == eif_pkg::IDX_ADDR_LO))
      |=> !sda_oe_n_out && (state == eif_pkg::ST_ACK);
  endproperty
  a_addr_ack_wi: assert property (p_addr_ack_wi) else $error("address byte not acked");

  property p_sel_match;
    byte_done && (byte_idx == eif_pkg::IDX_SEL) && sel_match(shreg, ce_f)
      |=> !sda_oe_n_out && (state == eif_pkg::ST_ACK) && (rw_bit == $past(shreg[0]));
  endproperty
  a_sel_match: assert property (p_sel_match) else $error("matching select not acked");

  property p_sel_miss;
    byte_done && (byte_idx == eif_pkg::IDX_SEL) && !sel_match(shreg, ce_f)
      |=> sda_oe_n_out && (state == eif_pkg::ST_IDLE);
  endproperty
  a_sel_miss: assert property (p_sel_miss) else $error("mismatched select not released");

  property p_stop_standby;
    stop_ev && !write_busy_in ##1 !write_busy_in |=> standby_out;
  endproperty
  a_stop_standby: assert property (p_stop_standby) else $error("no standby after stop");

  property p_write_start;
    stop_ev && wr_pend && (state == eif_pkg::ST_RECV) && (bit_cnt <= eif_pkg::BIT_STOP_SLOT)
      |=> write_start_out ##1 !write_start_out;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write cycle not started by stop");

  property p_busy_ignore;
    (state == eif_pkg::ST_IDLE) && write_busy_in |=> (state == eif_pkg::ST_IDLE);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start taken during write cycle");

  property p_start_recv;
    start_ev |=> (state == eif_pkg::ST_RECV) && (bit_cnt == eif_pkg::BIT_FIRST) && (byte_idx == eif_pkg::IDX_SEL);
  endproperty
  a_start_recv: assert property (p_start_recv) else $error("start not detected");

  property p_read_nack;
    (state == eif_pkg::ST_MACK) && bit_ev && link_bit && !stop_ev && !start_ev
      |=> (state == eif_pkg::ST_WAIT) ##1 sda_oe_n_out;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("no-ack did not end the read");

  property p_ack_release;
    (state == eif_pkg::ST_ACK) && scl_fall && (rw_bit != eif_pkg::RW_READ) && !stop_ev && !start_ev
      |=> sda_oe_n_out;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock");

endmodule

//--- hdl/eif_pkg.sv
package eif_pkg;

  // Select byte layout
  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_IDPAGE = 4'hB;
  localparam int SEL_TYPE_HI = 7;
  localparam int SEL_TYPE_LO = 4;
  localparam int SEL_CE_HI = 3;
  localparam int SEL_CE_LO = 1;
  localparam int SEL_RW = 0;
  localparam logic RW_READ = 1'b1;

  // Bit slots within one byte frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_MACK_SEEN = 4'h1;
  localparam logic [3:0] BIT_STOP_SLOT = 4'h1;

  // Byte index within one transfer
  localparam logic [1:0] IDX_SEL = 2'h0;
  localparam logic [1:0] IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;

  // Pin synchroniser lanes
  localparam int SYNC_W = 6;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_WI = 2;
  localparam int SYNC_CE_LO = 3;
  localparam int SYNC_CE_HI = 5;
  localparam logic [5:0] SYNC_RST = 6'h03;

  // Reset values
  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_SDA_OUT = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RECV = 6'h02,
    ST_ACK = 6'h04,
    ST_SEND = 6'h08,
    ST_MACK = 6'h10,
    ST_WAIT = 6'h20
  } eif_state_type;

endpackage

//--- hdl/eif_sync.sv
module eif_sync #(
  parameter int W = eif_pkg::SYNC_W,
  parameter logic [eif_pkg::SYNC_W-1:0] RST = eif_pkg::SYNC_RST
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Raw and filtered levels
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
          s1[i] <= RST[i];
          s2[i] <= RST[i];
          s3[i] <= RST[i];
          q_out[i] <= RST[i];
        end else begin
          s1[i] <= raw_in[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // A one-sample glitch never reaches q_out
          if (s2[i] == s3[i]) begin
            q_out[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule

//--- hdl/eif_link.sv
module eif_link (
  // Link clock and reset level
  input wire logic scl_clk_in,
  input wire logic rstn_in,
  // Serial data pin
  input wire logic sda_in,
  // Captured bit and its event toggle
  output logic bit_out,
  output logic tgl_out
);

  // Reset acts at once: SCL may stand still through a short reset, and release falls while SCL idles high
  always_ff @(posedge scl_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_out <= 1'b0;
      tgl_out <= 1'b0;
    end else begin
      bit_out <= sda_in;
      tgl_out <= ~tgl_out;
    end
  end

endmodule

//--- tb/eif_master.sv
module eif_master (
  // Bus lines driven by the master
  output logic scl_out,
  output logic sda_pull_out,
  // Resolved data wire
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock stands high between frames, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // Low phase first, so a repeated Start never sees the slave's ack as a Stop
  task automatic start_cond();
    #3;
    sda_pull_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 sda_pull_out = 1'b1;
    #40 scl_out = 1'b0;
    #40;
  endtask

  // Data changes only while the clock is low
  task automatic bit_w(input logic b);
    sda_pull_out = !b;
    #40 scl_out = 1'b1;
    #80 scl_out = 1'b0;
    #40;
  endtask

  task automatic bit_r(output logic b);
    sda_pull_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 b = sda_in;
    #40 scl_out = 1'b0;
    #40;
  endtask

  // Eight bits, most significant first, then the slave's ack slot
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_w(d[i]);
    bit_r(b);
    ack = !b;
  endtask

  task automatic byte_r(output logic [7:0] d, input logic mack);
    for (int i = 7; i >= 0; i--) bit_r(d[i]);
    bit_w(!mack);
  endtask

  task automatic stop_cond();
    sda_pull_out = 1'b1;
    #40 scl_out = 1'b1;
    #40 sda_pull_out = 1'b0;
    #40;
  endtask
endmodule

//--- tb/eif_slave_bench.sv
module eif_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_in = 1'b0;
  logic rstn_in;
  logic wi = 1'b0;
  logic busy = 1'b0;
  logic [2:0] strap = 3'h5;
  logic [7:0] rdata = 8'hC3;
  logic scl, sda_pull, sda_out, sda_oe_n, rx_valid, id_page, read_next, write_start, standby;
  logic [7:0] rx_byte;
  logic [1:0] rx_index;
  logic [3:0] acks;
  logic [7:0] d1, d2;
  logic [7:0] bad [3];
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_rx = 0;
  int n_ws = 0;
  int n_rn = 0;
  int b_rx, b_ws, b_rn;
  // Pull-up wins unless some party pulls low
  wire logic sda = !sda_pull && (sda_oe_n || sda_out);

  always #5 clk_in = ~clk_in;

  eif_slave dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .scl_clk_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .write_inhibit_input_in(wi),
    .chip_strap_bit0_in(strap[0]), .chip_strap_bit1_in(strap[1]), .chip_strap_bit2_in(strap[2]),
    .write_busy_in(busy), .read_data_in(rdata), .rx_byte_out(rx_byte), .rx_index_out(rx_index),
    .rx_valid_out(rx_valid), .id_page_out(id_page), .read_next_out(read_next),
    .write_start_out(write_start), .standby_out(standby)
  );

  eif_master m (.scl_out(scl), .sda_pull_out(sda_pull), .sda_in(sda));

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Pulses are counted so tests can compare how many landed
  always @(posedge clk_in) begin
    cycles++;
    if (rx_valid === 1'b1) n_rx++;
    if (write_start === 1'b1) n_ws++;
    // Array model: the next byte is offered once the current one is taken
    if (read_next === 1'b1) begin
      n_rn++;
      rdata <= rdata + 8'h11;
    end
    if (cycles == 30000) begin
      failures++;
      $display("Error at %0t: run did not finish", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic snap();
    b_rx = n_rx;
    b_ws = n_ws;
    b_rn = n_rn;
  endtask

  task automatic ended(input string n);
    $display("test %s finished", n);
  endtask

  task automatic xfer(input logic [7:0] sel, output logic [3:0] a4);
    logic [7:0] seq [4];
    logic a;
    seq = '{sel, 8'h12, 8'h34, 8'h56};
    m.start_cond();
    for (int i = 0; i < 4; i++) begin
      m.byte_w(seq[i], a);
      a4[3 - i] = a;
    end
    m.stop_cond();
    repeat (10) @(posedge clk_in);
  endtask

  initial begin
    bad = '{8'hA0, 8'h5A, 8'hAE};
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    // Reset raised again: a whole transfer sent meanwhile must be ignored
    @(posedge clk_in) rstn_in <= 1'b0;
    snap();
    xfer(8'hAA, acks);
    chk(8'(acks), 8'h00);
    chk(8'(standby), 8'h01);
    chk(8'(sda_oe_n), 8'h01);
    chk(8'(n_rx - b_rx), 8'h00);
    @(posedge clk_in) rstn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    ended("reset");

    snap();
    xfer(8'hAA, acks);
    chk(8'(acks), 8'h0F);
    chk(rx_byte, 8'h56);
    chk(8'(rx_index), 8'h03);
    chk(8'(n_rx - b_rx), 8'h04);
    chk(8'(n_ws - b_ws), 8'h01);
    chk(8'(standby), 8'h01);
    chk(8'(sda_out), 8'h00);
    ended("write");

    @(posedge clk_in) wi <= 1'b1;
    repeat (5) @(posedge clk_in);
    snap();
    xfer(8'hAA, acks);
    chk(8'(acks), 8'h0E);
    chk(8'(n_ws - b_ws), 8'h00);
    chk(8'(n_rx - b_rx), 8'h03);
    @(posedge clk_in) wi <= 1'b0;
    ended("inhibit");

    // Chip field off, type off, chip field all ones
    for (int i = 0; i < 3; i++) begin
      snap();
      xfer(bad[i], acks);
      chk(8'(acks), 8'h00);
      chk(8'(n_rx - b_rx), 8'h00);
      chk(8'(standby), 8'h01);
    end
    ended("mismatch");

    xfer(8'hBA, acks);
    chk(8'(acks), 8'h0F);
    chk(8'(id_page), 8'h01);
    xfer(8'hAA, acks);
    chk(8'(id_page), 8'h00);
    ended("id page");

    // Dummy write, repeated Start, then two bytes acked and not acked
    snap();
    m.start_cond();
    m.byte_w(8'hAA, acks[3]);
    m.byte_w(8'h00, acks[2]);
    m.byte_w(8'h10, acks[1]);
    m.start_cond();
    m.byte_w(8'hAB, acks[0]);
    m.byte_r(d1, 1'b1);
    m.byte_r(d2, 1'b0);
    m.stop_cond();
    repeat (10) @(posedge clk_in);
    chk(8'(acks), 8'h0F);
    chk(d1, 8'hC3);
    chk(d2, 8'hD4);
    chk(8'(n_rn - b_rn), 8'h02);
    chk(8'(n_ws - b_ws), 8'h00);
    chk(8'(standby), 8'h01);
    ended("read");

    @(posedge clk_in) busy <= 1'b1;
    repeat (3) @(posedge clk_in);
    snap();
    xfer(8'hAA, acks);
    chk(8'(acks), 8'h00);
    chk(8'(standby), 8'h00);
    chk(8'(n_ws - b_ws), 8'h00);
    @(posedge clk_in) busy <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk(8'(standby), 8'h01);
    ended("busy");

    @(posedge clk_in) rstn_in <= 1'b0;
    snap();
    xfer(8'hAA, acks);
    chk(8'(acks), 8'h00);
    chk(8'(n_rx - b_rx), 8'h00);
    @(posedge clk_in) rstn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    xfer(8'hAA, acks);
    chk(8'(acks), 8'h0F);
    ended("second reset");
    complete_run();
  end
endmodule
